/* File: hdl/smto_regs.vh */
// register map, field positions, reset values and timing figures of the
// smbus layer-1 timeout monitor; included by every design file
`ifndef SMTO_REGS_VH
`define SMTO_REGS_VH

// apb byte addresses (word aligned)
`define SMTO_ADDR_STATUS      8'h00
`define SMTO_ADDR_CONFIG      8'h04
`define SMTO_ADDR_MCTRL       8'h08
`define SMTO_ADDR_SCTRL       8'h0C
`define SMTO_ADDR_MADDR       8'h10
`define SMTO_ADDR_SYSCTL      8'h14

// timeout status bits
`define SMTO_ST_MCLK          0
`define SMTO_ST_SEXT          1
`define SMTO_ST_MEXT          2
`define SMTO_ST_SCLK          4
`define SMTO_ST_MASK          8'h17
`define SMTO_ST_MMASK         8'h07

// control_second bits
`define SMTO_CB_IRQEN         7
`define SMTO_CB_MEXTEN        6
`define SMTO_CB_SEXTEN        5
`define SMTO_CB_CLKEN         4
`define SMTO_CB_MMASK         8'hF0
`define SMTO_CB_SMASK         8'h90

// timeout_config fields
`define SMTO_CF_SSEL_HI       7
`define SMTO_CF_SSEL_LO       5
`define SMTO_CF_XSEL_HI       4
`define SMTO_CF_XSEL_LO       3
`define SMTO_CF_MSEL_HI       2
`define SMTO_CF_MSEL_LO       0

// own system control register: global irq enable and irq levels
`define SMTO_SC_GIE           0
`define SMTO_SC_MLVL_HI       2
`define SMTO_SC_MLVL_LO       1
`define SMTO_SC_SLVL_HI       4
`define SMTO_SC_SLVL_LO       3
`define SMTO_SC_MASK          8'h1F

`define SMTO_RST_BYTE         8'h00

// interrupt vector word offsets
`define SMTO_VEC_SLAVE        8'h00
`define SMTO_VEC_MASTER       8'h02

// timebase: 2 mhz tick, counts in ticks of 500 ns
`define SMTO_TICK_PER_MS      12'd2000
`define SMTO_CNT_W            16
`define SMTO_NOM_CLK_MS       6'd25
`define SMTO_NOM_SEXT_MS      6'd25
`define SMTO_NOM_MEXT_MS      6'd10
`define SMTO_MAX_RECOVER_MS   6'd35

`endif

/* File: hdl/smto_counter.v */
// one saturating timeout counter, ticking on the 2 mhz timebase
// assumes tick is a one-cycle strobe in the clk domain
`timescale 1ns/1ps
`include "smto_regs.vh"
module smto_counter (
  input  wire                    clk,
  input  wire                    resetn,
  input  wire                    ce,
  input  wire                    clear,
  input  wire                    run,
  input  wire                    tick,
  input  wire [`SMTO_CNT_W-1:0]  limit,
  output reg                     expired
);
  reg [`SMTO_CNT_W-1:0] count_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= {`SMTO_CNT_W{1'b0}};
      expired <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        count_q <= {`SMTO_CNT_W{1'b0}};
        expired <= 1'b0;
      end else if (run && tick && count_q < limit) begin
        count_q <= count_q + 1'b1;
        // expiry is a one-cycle pulse at the limit; counter then holds
        // there, so a long hold never wraps round to a second expiry
        expired <= (count_q + 1'b1 == limit);
      end else begin
        expired <= 1'b0;
      end
    end
  end
endmodule

/* File: hdl/smto_monitor.v */
// smbus layer-1 timeout monitor with master and slave halves, apb slave
// assumes scl/sda are raw pins; transfer engine supplies role and byte info
// Behaviour
// - flag clock-low timeout when scl stays low for the selected period.
// - flag slave extension when summed slave stretch start-to-stop reaches period.
// - flag master extension when stretch within one byte segment reaches period.
// - slave clock-low timeout resets slave engine and releases both lines.
// - master clock-low timeout makes the master send stop itself.
// - master clock-low counter disabled after arbitration loss.
// - extension timeout: stop now if master owns sda, else after byte.
// - after extension timeout slave resets on the master's stop.
// - extension counters disabled after arbitration loss.
// - master and slave keep independent counters for bridge operation.
// - clock-low timeout recovery lets a new start be taken within 35 ms.
// - irq needs enable, a flag, global enable and nonzero level.
// - any timeout clears status bits except bus error; config unchanged.
// - master irq enable covers all three master timeout flags.
// - master extension enable arms that monitor and its flag.
// - slave extension enable arms that monitor and its flag.
// - master clock-low enable arms that monitor and its flag.
// - config register shifts each period: separate master and slave clock-low codes, one extension code for both.
// - slave vector at word offset 0x00, master vector at 0x02.
// - 3-bit clock-low code: 000..011 25..22 ms, 100..111 26..29 ms.
// - 2-bit extension code: 25/10, 24/9, 26/11, 27/12 ms.
// - write one clears a flag; master address write clears master flags.
// - slave clock-low enable arms slave monitor; slave irq enable gates it.
`timescale 1ns/1ps
`include "smto_regs.vh"
module smto_monitor (
  input  wire        clk,
  input  wire        resetn,
  input  wire        ce,
  input  wire        osc_tick,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        scl_in,
  input  wire        sda_in,
  input  wire        master_active,
  input  wire        master_owns_sda,
  input  wire        arb_lost,
  input  wire        byte_ack,
  input  wire        master_stretch,
  input  wire        slave_stretch,
  input  wire        slave_active,
  input  wire        bus_err_in,
  output reg         master_stop_req,
  output reg         slave_reset,
  output reg         status_clear,
  output wire        scl_out,
  output wire        scl_oe,
  output wire        sda_out,
  output wire        sda_oe,
  output wire        master_irq,
  output wire        slave_irq,
  output wire [7:0]  master_vector,
  output wire [7:0]  slave_vector
);
  // recovery states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_STOP = 3'b100;

  reg [7:0] status_q;
  reg [7:0] config_q;
  reg [7:0] mctrl_q;
  reg [7:0] sctrl_q;
  reg [7:0] sysctl_q;
  reg [1:0] scl_sync_q;
  reg [1:0] sda_sync_q;
  reg       scl_q;
  reg       sda_q;
  reg       in_xfer_q;
  reg       arb_lost_q;
  reg       ext_pend_q;
  reg [2:0] mstate_q;
  reg [2:0] mstate_d;
  reg [7:0] rd_byte_d;

  // ms count from selection; period in 500 ns ticks
  function [`SMTO_CNT_W-1:0] ms_to_ticks;
    input [5:0] ms;
    begin
      // both factors widened so the product is formed at counter width;
      // the longest selection, 29 ms, still fits in sixteen bits
      ms_to_ticks = {{(`SMTO_CNT_W-6){1'b0}}, ms}
                    * {{(`SMTO_CNT_W-12){1'b0}}, `SMTO_TICK_PER_MS};
    end
  endfunction

  function [5:0] clk_low_ms;
    input [2:0] sel;
    begin
      if (sel[2])
        clk_low_ms = `SMTO_NOM_CLK_MS + {4'h0, sel[1:0]} + 6'd1;
      else
        clk_low_ms = `SMTO_NOM_CLK_MS - {4'h0, sel[1:0]};
    end
  endfunction

  function [5:0] ext_ms;
    input [1:0] sel;
    input [5:0] nom;
    begin
      case (sel)
        2'b01:   ext_ms = nom - 6'd1;
        2'b10:   ext_ms = nom + 6'd1;
        2'b11:   ext_ms = nom + 6'd2;
        default: ext_ms = nom;
      endcase
    end
  endfunction

  // one gate for both irq lines: enable, global enable, a flag, a level
  function irq_gate;
    input       en;
    input       all_en;
    input       flag;
    input [1:0] level;
    begin
      irq_gate = en && all_en && flag && (|level);
    end
  endfunction

  wire [2:0] ssel = config_q[`SMTO_CF_SSEL_HI:`SMTO_CF_SSEL_LO];
  wire [1:0] xsel = config_q[`SMTO_CF_XSEL_HI:`SMTO_CF_XSEL_LO];
  wire [2:0] msel = config_q[`SMTO_CF_MSEL_HI:`SMTO_CF_MSEL_LO];
  wire [`SMTO_CNT_W-1:0] mclk_lim = ms_to_ticks(clk_low_ms(msel));
  wire [`SMTO_CNT_W-1:0] sclk_lim = ms_to_ticks(clk_low_ms(ssel));
  wire [`SMTO_CNT_W-1:0] sext_lim =
    ms_to_ticks(ext_ms(xsel, `SMTO_NOM_SEXT_MS));
  wire [`SMTO_CNT_W-1:0] mext_lim =
    ms_to_ticks(ext_ms(xsel, `SMTO_NOM_MEXT_MS));

  // pins pass two flops before any logic reads them
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else if (ce) begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  wire scl_s    = scl_sync_q[1];
  wire sda_s    = sda_sync_q[1];
  wire start_ev = scl_s && scl_q && sda_q && !sda_s;
  wire stop_ev  = scl_s && scl_q && !sda_q && sda_s;

  // transfer window and arbitration-loss memory until the next start
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_xfer_q  <= 1'b0;
      arb_lost_q <= 1'b0;
    end else if (ce) begin
      if (start_ev) begin
        in_xfer_q  <= 1'b1;
        arb_lost_q <= 1'b0;
      end else begin
        if (stop_ev)
          in_xfer_q <= 1'b0;
        if (arb_lost)
          arb_lost_q <= 1'b1;
      end
    end
  end

  wire m_dis = arb_lost || arb_lost_q;

  wire mclk_exp;
  wire sclk_exp;
  wire sext_exp;
  wire mext_exp;
  // separate instances per side so bridge operation times both at once
  smto_counter u_mclk (
    .clk     (clk),
    .resetn  (resetn),
    .ce      (ce),
    .clear   (scl_s || m_dis),
    .run     (master_active && mctrl_q[`SMTO_CB_CLKEN]),
    .tick    (osc_tick),
    .limit   (mclk_lim),
    .expired (mclk_exp)
  );
  smto_counter u_sclk (
    .clk     (clk),
    .resetn  (resetn),
    .ce      (ce),
    .clear   (scl_s),
    .run     (slave_active && sctrl_q[`SMTO_CB_CLKEN]),
    .tick    (osc_tick),
    .limit   (sclk_lim),
    .expired (sclk_exp)
  );
  smto_counter u_sext (
    .clk     (clk),
    .resetn  (resetn),
    .ce      (ce),
    .clear   (start_ev || m_dis),
    .run     (in_xfer_q && slave_stretch && !scl_s
              && mctrl_q[`SMTO_CB_SEXTEN]),
    .tick    (osc_tick),
    .limit   (sext_lim),
    .expired (sext_exp)
  );
  smto_counter u_mext (
    .clk     (clk),
    .resetn  (resetn),
    .ce      (ce),
    .clear   (start_ev || byte_ack || stop_ev || m_dis),
    .run     (in_xfer_q && master_stretch && !scl_s
              && mctrl_q[`SMTO_CB_MEXTEN]),
    .tick    (osc_tick),
    .limit   (mext_lim),
    .expired (mext_exp)
  );

  wire any_to = mclk_exp || sclk_exp || sext_exp || mext_exp;

  // apb: zero wait state, unmapped reads zero with pslverr
  wire acc    = psel && penable;
  wire wr     = acc && pwrite;
  wire mapped = (paddr == `SMTO_ADDR_STATUS) || (paddr == `SMTO_ADDR_CONFIG)
             || (paddr == `SMTO_ADDR_MCTRL) || (paddr == `SMTO_ADDR_SCTRL)
             || (paddr == `SMTO_ADDR_MADDR) || (paddr == `SMTO_ADDR_SYSCTL);
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  wire [7:0] w1c   = (wr && paddr == `SMTO_ADDR_STATUS) ?
                     (pwdata[7:0] & `SMTO_ST_MASK) : `SMTO_RST_BYTE;
  wire [7:0] mclr  = (wr && paddr == `SMTO_ADDR_MADDR) ?
                     `SMTO_ST_MMASK : `SMTO_RST_BYTE;
  wire [7:0] setv  = {3'b000, sclk_exp, 1'b0, mext_exp, sext_exp, mclk_exp};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= `SMTO_RST_BYTE;
      config_q <= `SMTO_RST_BYTE;
      mctrl_q  <= `SMTO_RST_BYTE;
      sctrl_q  <= `SMTO_RST_BYTE;
      sysctl_q <= `SMTO_RST_BYTE;
    end else if (ce) begin
      // set wins over a same-cycle clear
      status_q <= (status_q & ~(w1c | mclr)) | setv;
      if (wr && paddr == `SMTO_ADDR_CONFIG)
        config_q <= pwdata[7:0];
      if (wr && paddr == `SMTO_ADDR_MCTRL)
        mctrl_q <= pwdata[7:0] & `SMTO_CB_MMASK;
      if (wr && paddr == `SMTO_ADDR_SCTRL)
        sctrl_q <= pwdata[7:0] & `SMTO_CB_SMASK;
      if (wr && paddr == `SMTO_ADDR_SYSCTL)
        sysctl_q <= pwdata[7:0] & `SMTO_SC_MASK;
    end
  end

  always @* begin
    case (paddr)
      `SMTO_ADDR_STATUS: rd_byte_d = status_q;
      `SMTO_ADDR_CONFIG: rd_byte_d = config_q;
      `SMTO_ADDR_MCTRL:  rd_byte_d = mctrl_q;
      `SMTO_ADDR_SCTRL:  rd_byte_d = sctrl_q;
      `SMTO_ADDR_SYSCTL: rd_byte_d = sysctl_q;
      default:           rd_byte_d = `SMTO_RST_BYTE;
    endcase
  end

  // read data is taken in the setup cycle, so it leaves a flop in the
  // access cycle; a flag set between the two shows on the next read
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (ce) begin
      if (psel && !penable)
        prdata <= {24'h000000, rd_byte_d};
    end
  end

  // recovery: master stop request, slave reset and line release
  always @* begin
    mstate_d = mstate_q;
    case (mstate_q)
      ST_IDLE: begin
        if (mclk_exp)
          mstate_d = ST_STOP;
        else if ((sext_exp || mext_exp) && master_active)
          mstate_d = master_owns_sda ? ST_STOP : ST_WAIT;
      end
      ST_WAIT: begin
        // lost arbitration leaves this master no stop to send
        if (m_dis)
          mstate_d = ST_IDLE;
        else if (byte_ack || master_owns_sda)
          mstate_d = ST_STOP;
      end
      ST_STOP: mstate_d = ST_IDLE;
      default: mstate_d = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mstate_q        <= ST_IDLE;
      master_stop_req <= 1'b0;
      slave_reset     <= 1'b0;
      status_clear    <= 1'b0;
      ext_pend_q      <= 1'b0;
    end else if (ce) begin
      mstate_q        <= mstate_d;
      master_stop_req <= (mstate_d == ST_STOP);
      status_clear    <= any_to && !bus_err_in;
      // clock-low resets at once, well inside the 35 ms window
      slave_reset     <= sclk_exp || (ext_pend_q && stop_ev);
      if (sext_exp || mext_exp)
        ext_pend_q <= 1'b1;
      else if (stop_ev || start_ev)
        ext_pend_q <= 1'b0;
    end
  end

  // this monitor never drives the lines; release is forced by slave_reset
  assign scl_out = 1'b0;
  assign scl_oe  = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe  = 1'b0;

  wire gie = sysctl_q[`SMTO_SC_GIE];
  assign master_irq = irq_gate(mctrl_q[`SMTO_CB_IRQEN], gie,
    |status_q[`SMTO_ST_MEXT:`SMTO_ST_MCLK],
    sysctl_q[`SMTO_SC_MLVL_HI:`SMTO_SC_MLVL_LO]);
  assign slave_irq = irq_gate(sctrl_q[`SMTO_CB_IRQEN], gie,
    status_q[`SMTO_ST_SCLK],
    sysctl_q[`SMTO_SC_SLVL_HI:`SMTO_SC_SLVL_LO]);
  assign master_vector = `SMTO_VEC_MASTER;
  assign slave_vector  = `SMTO_VEC_SLAVE;
endmodule

/* File: dv/smto_monitor_sva.sv */
// port checks of the timeout monitor
// assumes apb writes are the only way its irq controls change
`timescale 1ns/1ps
`include "smto_regs.vh"
module smto_monitor_sva (
  input wire        clk,
  input wire        resetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        arb_lost,
  input wire        bus_err_in,
  input wire        master_stop_req,
  input wire        slave_reset,
  input wire        status_clear,
  input wire        scl_oe,
  input wire        sda_oe,
  input wire        master_irq,
  input wire        slave_irq,
  input wire [7:0]  master_vector,
  input wire [7:0]  slave_vector
);
  reg  [4:0] sys_q;
  reg        mie_q;
  reg        sie_q;
  wire       wr = psel && penable && pwrite;
  // shadow of the gating controls, so irq can be tied to its enables
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sys_q <= 5'h00;
      mie_q <= 1'b0;
      sie_q <= 1'b0;
    end else if (wr) begin
      if (paddr == `SMTO_ADDR_SYSCTL) sys_q <= pwdata[4:0];
      if (paddr == `SMTO_ADDR_MCTRL) mie_q <= pwdata[7];
      if (paddr == `SMTO_ADDR_SCTRL) sie_q <= pwdata[7];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_mirq_gate: assert property (
    master_irq |-> sys_q[0] && sys_q[2:1] != 2'b00 && mie_q)
    else $error("master irq without its enables");
  a_sirq_gate: assert property (
    slave_irq |-> sys_q[0] && sys_q[4:3] != 2'b00 && sie_q)
    else $error("slave irq without its enables");
  a_stop_pulse: assert property (
    master_stop_req |=> !master_stop_req)
    else $error("stop request longer than one cycle");
  a_reset_pulse: assert property (
    slave_reset |=> !slave_reset)
    else $error("slave reset longer than one cycle");
  a_clear_buserr: assert property (
    bus_err_in && $past(bus_err_in) |-> !status_clear)
    else $error("status clear during bus error");
  a_arb_nostop: assert property (
    arb_lost [*3] |-> !master_stop_req)
    else $error("stop request after arbitration loss");
  a_lines_free: assert property (
    !scl_oe && !sda_oe)
    else $error("monitor drives a bus line");
  a_vector_fix: assert property (
    master_vector == `SMTO_VEC_MASTER && slave_vector == `SMTO_VEC_SLAVE)
    else $error("interrupt vector offsets wrong");
  a_addr_clear: assert property (
    wr && paddr == `SMTO_ADDR_MADDR |=> !master_irq)
    else $error("master irq kept after address write");
endmodule
bind smto_monitor smto_monitor_sva u_sva (.clk(clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .arb_lost(arb_lost), .bus_err_in(bus_err_in),
  .master_stop_req(master_stop_req), .slave_reset(slave_reset),
  .status_clear(status_clear), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .master_irq(master_irq), .slave_irq(slave_irq),
  .master_vector(master_vector), .slave_vector(slave_vector));

/* File: dv/smto_bus_peer.sv */
// far-side bus device: start, stop, clocked bits and stuck-low holds
// assumes open-drain lines with pull-ups resolved by the bench
`timescale 1ns/1ps
module smto_bus_peer (
  input  wire clk,
  output reg  scl_o,
  output reg  sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // every change lands 10 ns after a clk edge, never on one
  task start_cond;
    begin
      #10 sda_o = 1'b0;
      #160 scl_o = 1'b0;
    end
  endtask
  // link clock only runs inside a frame
  task clock_bits(input integer n);
    repeat (n) begin
      #160 scl_o = 1'b1;
      #160 scl_o = 1'b0;
    end
  endtask
  // offset from the edge so the sync flops never race the change
  task hold_low(input integer n);
    begin
      #10 scl_o = 1'b0;
      repeat (n) @(posedge clk);
      #10 scl_o = 1'b1;
    end
  endtask
  task stop_cond;
    begin
      #10 sda_o = 1'b0;
      #160 scl_o = 1'b1;
      #160 sda_o = 1'b1;
    end
  endtask
endmodule

/* File: dv/smto_monitor_tb.sv */
// self-checking bench for the timeout monitor over apb
// assumes the tick strobe held high, so one tick per clk cycle
`timescale 1ns/1ps
`include "smto_regs.vh"
module smto_monitor_tb;
  localparam [111:0] TBL = 112'h0000_04FF_08F0_0C90_1000_141F_1800;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg         master_active = 1'b0;
  reg         master_owns_sda = 1'b0;
  reg         arb_lost = 1'b0;
  reg         byte_ack = 1'b0;
  reg         slave_stretch = 1'b0;
  reg         master_stretch = 1'b0;
  reg         slave_active = 1'b0;
  reg         bus_err_in = 1'b0;
  wire [31:0] prdata;
  wire        pready, pslverr, master_stop_req, slave_reset, status_clear;
  wire        scl_out, scl_oe, sda_out, sda_oe, master_irq, slave_irq;
  wire        scl_o, sda_o;
  wire [7:0]  master_vector, slave_vector;
  wire        scl_in = scl_o & ~(scl_oe & ~scl_out);
  wire        sda_in = sda_o & ~(sda_oe & ~sda_out);
  integer     cyc = 0, err_count = 0, samples_checked = 0, i, t0;
  integer     stop_cnt = 0, rst_cnt = 0, clr_cnt = 0;
  reg  [31:0] q;
  reg         e;
  reg  [7:0]  a;
  smto_bus_peer peer (.clk, .scl_o, .sda_o);
  smto_monitor uut (.clk, .resetn, .ce(1'b1), .osc_tick(1'b1),
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .scl_in, .sda_in, .master_active, .master_owns_sda,
    .arb_lost, .byte_ack, .master_stretch, .slave_stretch,
    .slave_active, .bus_err_in, .master_stop_req, .slave_reset,
    .status_clear, .scl_out, .scl_oe, .sda_out, .sda_oe, .master_irq,
    .slave_irq, .master_vector, .slave_vector);
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    stop_cnt <= stop_cnt + master_stop_req;
    rst_cnt <= rst_cnt + slave_reset;
    clr_cnt <= clr_cnt + status_clear;
    // the tests need about 87000 cycles
    if (cyc == 92000) begin
      err_count = err_count + 1;
      summarize;
    end
  end
  task summarize;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input [95:0] what);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0s exp %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task apb(input w, input [7:0] ad, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [7:0] ad, input [7:0] exp);
    begin
      apb(1'b0, ad, 32'h0);
      chk(q, {24'h0, exp}, "status");
    end
  endtask
  task wait_to(input integer t);
    while (cyc < t) @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      a = TBL[16*i+8 +: 8];
      apb(1'b0, a, 32'h0);
      chk(q, 32'h0, "reset read");
      chk(e, a == 8'h18, "pslverr");
      apb(1'b1, a, 32'hFF);
      apb(1'b0, a, 32'h0);
      chk(q, TBL[16*i +: 8], "readback");
      apb(1'b1, a, 32'h0);
    end
    chk(master_vector, `SMTO_VEC_MASTER, "master vec");
    chk(slave_vector, `SMTO_VEC_SLAVE, "slave vec");
    $display("register test done");
    apb(1'b1, `SMTO_ADDR_CONFIG, 32'h03);
    apb(1'b1, `SMTO_ADDR_MCTRL, 32'h90);
    apb(1'b1, `SMTO_ADDR_SCTRL, 32'h10);
    apb(1'b1, `SMTO_ADDR_SYSCTL, 32'h03);
    master_active <= 1'b1;
    slave_active <= 1'b1;
    @(posedge clk);
    t0 = cyc;
    fork peer.hold_low(50100); join_none
    wait_to(t0 + 43990);
    rd(`SMTO_ADDR_STATUS, 8'h00);
    wait_to(t0 + 44040);
    rd(`SMTO_ADDR_STATUS, 8'h01);
    chk(master_irq, 1, "master irq");
    chk(stop_cnt, 1, "stop count");
    chk(clr_cnt, 1, "clear count");
    bus_err_in <= 1'b1;
    wait_to(t0 + 49990);
    rd(`SMTO_ADDR_STATUS, 8'h01);
    wait_to(t0 + 50040);
    rd(`SMTO_ADDR_STATUS, 8'h11);
    chk(rst_cnt, 1, "slave reset");
    chk(clr_cnt, 1, "clear count");
    chk(slave_irq, 0, "slave irq");
    apb(1'b1, `SMTO_ADDR_SCTRL, 32'h90);
    apb(1'b1, `SMTO_ADDR_SYSCTL, 32'h1B);
    @(posedge clk);
    chk(slave_irq, 1, "slave irq");
    wait_to(t0 + 50120);
    master_active <= 1'b0;
    slave_active <= 1'b0;
    bus_err_in <= 1'b0;
    apb(1'b1, `SMTO_ADDR_MADDR, 32'h0);
    rd(`SMTO_ADDR_STATUS, 8'h10);
    chk(master_irq, 0, "master irq");
    apb(1'b1, `SMTO_ADDR_STATUS, 32'h10);
    rd(`SMTO_ADDR_STATUS, 8'h00);
    $display("clock low test done");
    apb(1'b1, `SMTO_ADDR_CONFIG, 32'h08);
    apb(1'b1, `SMTO_ADDR_MCTRL, 32'hC0);
    master_active <= 1'b1;
    peer.start_cond;
    peer.clock_bits(9);
    @(posedge clk);
    master_stretch <= 1'b1;
    t0 = cyc;
    fork peer.hold_low(18100); join_none
    wait_to(t0 + 17990);
    rd(`SMTO_ADDR_STATUS, 8'h00);
    wait_to(t0 + 18030);
    rd(`SMTO_ADDR_STATUS, 8'h04);
    chk(stop_cnt, 1, "stop wait");
    chk(master_irq, 1, "master irq");
    byte_ack <= 1'b1;
    @(posedge clk);
    byte_ack <= 1'b0;
    repeat (2) @(posedge clk);
    chk(stop_cnt, 2, "stop count");
    master_stretch <= 1'b0;
    wait_to(t0 + 18120);
    peer.stop_cond;
    apb(1'b1, `SMTO_ADDR_STATUS, 32'h04);
    rd(`SMTO_ADDR_STATUS, 8'h00);
    chk(rst_cnt, 2, "slave reset");
    $display("extension test done");
    peer.start_cond;
    peer.clock_bits(9);
    @(posedge clk);
    arb_lost <= 1'b1;
    repeat (3) @(posedge clk);
    arb_lost <= 1'b0;
    master_stretch <= 1'b1;
    t0 = cyc;
    fork peer.hold_low(18100); join_none
    wait_to(t0 + 18030);
    rd(`SMTO_ADDR_STATUS, 8'h00);
    chk(stop_cnt, 2, "stop count");
    master_stretch <= 1'b0;
    wait_to(t0 + 18120);
    peer.stop_cond;
    master_active <= 1'b0;
    $display("arbitration test done");
    summarize;
  end
endmodule
